// ---- dopr_output_router.sv ----
// Digital output stage with polarity, forcing, routing and brake PWM
module dopr_output_router
  import dopr_pkg::*;
#(
  parameter int NUM_OUT      = 4,
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire dopr_od_req_t          odReq,
  output dopr_od_rsp_t               odRsp,
  input  wire logic [31:0]           encoderCount,
  input  wire logic [31:0]           positionValue,
  input  wire logic                  errorState,
  input  wire logic [NUM_OUT+1:0]    pinIn,
  output logic      [NUM_OUT+1:0]    pinOut,
  output logic      [NUM_OUT+1:0]    pinOe,
  output logic                       ledGreen,
  output logic                       ledRed
);

  localparam int PIN_W = NUM_OUT + 2;
  localparam int BW    = $clog2(BLINK_CYCLES + 1);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (NUM_OUT < 1 || NUM_OUT > 16) begin : g_chk_out
    $error("NUM_OUT must lie between 1 and 16");
  end
  if (BLINK_CYCLES < 1) begin : g_chk_blink
    $error("BLINK_CYCLES must be at least one");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0]               ctrl;
    logic [31:0]               pol;
    logic [31:0]               forceEn;
    logic [31:0]               forceVal;
    logic [31:0]               routeEn;
    logic [31:0]               ledCtrl;
    logic [NUM_OUT:0][15:0]    route;
    logic [31:0]               brkFreq;
    logic [6:0]                brkDuty;
    logic [ACC_W-1:0]          pwmAcc;
    logic [6:0]                pwmPct;
    logic [BW-1:0]             blinkCnt;
    logic                      blinkPhase;
    logic [31:0]               applied;
    logic [PIN_W-1:0]          pinLow;
    logic [PIN_W-1:0]          pinDrive;
    logic                      green;
    logic                      red;
    dopr_od_rsp_t              rsp;
  } dopr_state_t;

  dopr_state_t state_reg;
  dopr_state_t state_next;

  logic [NUM_DIV-1:0] encPulse;
  logic [NUM_DIV-1:0] posPulse;
  logic [23:0]        reqKey;

  assign reqKey = {odReq.index, odReq.sub};

  // ------------------------------------------------------------
  // Increment pulse sources
  // ------------------------------------------------------------
  dopr_incr_pulse #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_enc_pulse (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .countValue (encoderCount),
    .pulseLevel (encPulse)
  );

  dopr_incr_pulse #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_pos_pulse (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .countValue (positionValue),
    .pulseLevel (posPulse)
  );

  // ------------------------------------------------------------
  // Source level of one routing entry
  // ------------------------------------------------------------
  function automatic logic srcLevel(
    input logic [7:0]         src,
    input logic [NUM_DIV-1:0] enc,
    input logic [NUM_DIV-1:0] pos,
    input logic               pwm
  );
    logic [7:0] ofs;
    srcLevel = 1'b0;
    ofs      = 8'h00;
    if (src == SRC_ONE) begin
      srcLevel = 1'b1;
    end else if (src == SRC_ZERO) begin
      srcLevel = 1'b0;
    end else if (src >= SRC_ENC_FIRST && src <= SRC_ENC_LAST) begin
      ofs      = src - SRC_ENC_FIRST;
      srcLevel = enc[ofs[2:0]];
    end else if (src >= SRC_POS_FIRST && src <= SRC_POS_LAST) begin
      ofs      = src - SRC_POS_FIRST;
      srcLevel = pos[ofs[2:0]];
    end else if (src == SRC_PWM) begin
      srcLevel = pwm;
    end else if (src == SRC_PWM_INV) begin
      srcLevel = ~pwm;
    end
  endfunction : srcLevel

  // ------------------------------------------------------------
  // Routed level of one entry
  // ------------------------------------------------------------
  function automatic logic routeLevel(
    input logic [15:0]        entry,
    input logic [31:0]        ctrl,
    input logic [NUM_DIV-1:0] enc,
    input logic [NUM_DIV-1:0] pos,
    input logic               pwm
  );
    logic gate;
    gate       = ctrl[entry[4:0]] ^ entry[ROUTE_INV_BIT];
    routeLevel = gate & srcLevel(entry[15:8], enc, pos, pwm);
  endfunction : routeLevel

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic                    hit;
    logic                    bad;
    logic [31:0]             rdVal;
    logic [ACC_W-1:0]        accSum;
    logic [ACC_W-1:0]        step;
    logic                    pwmLevel;
    logic                    routing;
    logic [31:0]             level;
    logic [31:0]             final_;
    logic                    softLevel;
    hit        = 1'b1;
    bad        = 1'b0;
    rdVal      = '0;
    accSum     = '0;
    step       = '0;
    pwmLevel   = 1'b0;
    routing    = 1'b0;
    level      = '0;
    final_     = '0;
    softLevel  = 1'b0;
    state_next = state_reg;
    state_next.rsp = '0;

    // Object access
    if (odReq.wr || odReq.rd) begin
      case (reqKey)
        KEY_OUT_CTRL: begin
          rdVal = state_reg.ctrl;
          if (odReq.wr) state_next.ctrl = odReq.data;
        end
        KEY_POLARITY: begin
          rdVal = state_reg.pol;
          if (odReq.wr) state_next.pol = odReq.data;
        end
        KEY_FORCE_EN: begin
          rdVal = state_reg.forceEn;
          if (odReq.wr) state_next.forceEn = odReq.data;
        end
        KEY_FORCE_VAL: begin
          rdVal = state_reg.forceVal;
          if (odReq.wr) state_next.forceVal = odReq.data;
        end
        KEY_APPLIED: begin
          rdVal = state_reg.applied;
          bad   = odReq.wr;
        end
        KEY_ROUTE_EN: begin
          rdVal = state_reg.routeEn;
          if (odReq.wr) state_next.routeEn = odReq.data;
        end
        KEY_LED_CTRL: begin
          rdVal = state_reg.ledCtrl;
          if (odReq.wr) state_next.ledCtrl = odReq.data;
        end
        KEY_BRK_FREQ: begin
          rdVal = state_reg.brkFreq;
          if (odReq.wr) begin
            if (odReq.data > BRK_FREQ_MAX) begin
              bad = 1'b1;
            end else begin
              state_next.brkFreq = odReq.data;
            end
          end
        end
        KEY_BRK_DUTY: begin
          rdVal = {25'h0000000, state_reg.brkDuty};
          if (odReq.wr) begin
            if (odReq.data < 32'(DUTY_MIN) || odReq.data > 32'(DUTY_MAX)) begin
              bad = 1'b1;
            end else begin
              state_next.brkDuty = odReq.data[6:0];
            end
          end
        end
        default: begin
          hit = 1'b0;
          if (odReq.index == OBJ_ROUTE) begin
            for (int e = 0; e <= NUM_OUT; e++) begin
              if (odReq.sub == 8'(e + 1)) begin
                hit   = 1'b1;
                rdVal = {16'h0000, state_reg.route[e]};
                if (odReq.wr) state_next.route[e] = odReq.data[15:0];
              end
            end
          end
        end
      endcase
      state_next.rsp.ack  = 1'b1;
      state_next.rsp.err  = ~hit | bad;
      state_next.rsp.data = (odReq.rd && hit) ? rdVal : '0;
    end

    // Brake PWM: percent steps at 100 times the set frequency
    step   = ACC_W'(state_reg.brkFreq[10:0]) * ACC_W'(PCT_PER_HZ);
    accSum = state_reg.pwmAcc + step;
    if (accSum >= ACC_MOD) begin
      state_next.pwmAcc = accSum - ACC_MOD;
      state_next.pwmPct = (state_reg.pwmPct == PCT_LAST) ? 7'h00
                          : state_reg.pwmPct + 7'h01;
    end else begin
      state_next.pwmAcc = accSum;
    end
    pwmLevel = (state_reg.brkDuty >= DUTY_MAX) ? 1'b1
               : (state_reg.pwmPct < state_reg.brkDuty);

    // Level paths
    routing = (state_reg.routeEn == ROUTE_EN_ON);
    level[BRAKE_BIT] = state_reg.ctrl[BRAKE_BIT] & pwmLevel;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (routing) begin
        level[OUT_BIT_BASE + i] = routeLevel(state_reg.route[i + 1],
                                             state_reg.ctrl, encPulse, posPulse,
                                             pwmLevel);
      end else begin
        level[OUT_BIT_BASE + i] = state_reg.ctrl[OUT_BIT_BASE + i];
      end
    end
    softLevel = routing && routeLevel(state_reg.route[0], state_reg.ctrl,
                                      encPulse, posPulse, pwmLevel);

    // Polarity on the unforced value, then force
    final_ = (state_reg.forceEn & state_reg.forceVal)
           | (~state_reg.forceEn & (level ^ state_reg.pol));
    state_next.applied = '0;
    state_next.applied[BRAKE_BIT] = final_[BRAKE_BIT];
    for (int i = 0; i < NUM_OUT; i++) begin
      state_next.applied[OUT_BIT_BASE + i] = final_[OUT_BIT_BASE + i];
    end

    // Open-drain pins: active level sinks, idle level releases
    state_next.pinLow = '0;
    state_next.pinDrive[PIN_BRAKE]    = final_[BRAKE_BIT];
    state_next.pinDrive[PIN_SOFT_PWM] = softLevel;
    for (int i = 0; i < NUM_OUT; i++) begin
      state_next.pinDrive[PIN_OUT_BASE + i] = final_[OUT_BIT_BASE + i];
    end

    // Status LEDs blink from a divided enable
    if (state_reg.blinkCnt == BW'(BLINK_CYCLES - 1)) begin
      state_next.blinkCnt   = '0;
      state_next.blinkPhase = ~state_reg.blinkPhase;
    end else begin
      state_next.blinkCnt = state_reg.blinkCnt + BW'(1);
    end
    state_next.green = state_reg.ledCtrl[LED_GREEN_BIT] & ~errorState
                       & state_reg.blinkPhase;
    state_next.red   = state_reg.ledCtrl[LED_RED_BIT] & errorState
                       & state_reg.blinkPhase;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg         <= '0;
      state_reg.brkFreq <= BRK_FREQ_RST;
      state_reg.brkDuty <= DUTY_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign odRsp    = state_reg.rsp;
  assign pinOut   = state_reg.pinLow;
  assign pinOe    = state_reg.pinDrive;
  assign ledGreen = state_reg.green;
  assign ledRed   = state_reg.red;

endmodule : dopr_output_router

// ---- dopr_pkg.sv ----
// Shared constants and carrier types of the digital output port router
package dopr_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ      = 250_000_000;
  localparam int PULSE_US    = 100;
  localparam int PULSE_CYC   = (CLK_HZ / 1_000_000) * PULSE_US;
  localparam int BLINK_MS    = 250;
  localparam int BLINK_CYC   = (CLK_HZ / 1_000) * BLINK_MS;

  // ------------------------------------------------------------
  // Object keys: index in the upper 16 bits, subindex in the lower 8
  // ------------------------------------------------------------
  localparam logic [15:0] OBJ_ROUTE      = 16'h3252;
  localparam logic [23:0] KEY_OUT_CTRL   = 24'h60FE01;
  localparam logic [23:0] KEY_POLARITY   = 24'h325002;
  localparam logic [23:0] KEY_FORCE_EN   = 24'h325003;
  localparam logic [23:0] KEY_FORCE_VAL  = 24'h325004;
  localparam logic [23:0] KEY_APPLIED    = 24'h325005;
  localparam logic [23:0] KEY_ROUTE_EN   = 24'h325008;
  localparam logic [23:0] KEY_LED_CTRL   = 24'h325009;
  localparam logic [23:0] KEY_BRK_FREQ   = 24'h203805;
  localparam logic [23:0] KEY_BRK_DUTY   = 24'h203806;

  // ------------------------------------------------------------
  // Field positions and values
  // ------------------------------------------------------------
  localparam int          OUT_BIT_BASE   = 16;
  localparam int          BRAKE_BIT      = 0;
  localparam int          LED_GREEN_BIT  = 0;
  localparam int          LED_RED_BIT    = 1;
  localparam int          ROUTE_INV_BIT  = 7;
  localparam int          PIN_BRAKE      = 0;
  localparam int          PIN_SOFT_PWM   = 1;
  localparam int          PIN_OUT_BASE   = 2;
  localparam logic [31:0] ROUTE_EN_ON    = 32'h0000_0001;
  localparam int          NUM_DIV        = 7;

  // ------------------------------------------------------------
  // Routing source codes (upper byte of an entry)
  // ------------------------------------------------------------
  localparam logic [7:0]  SRC_ONE        = 8'h00;
  localparam logic [7:0]  SRC_ZERO       = 8'h01;
  localparam logic [7:0]  SRC_ENC_FIRST  = 8'h02;
  localparam logic [7:0]  SRC_ENC_LAST   = 8'h08;
  localparam logic [7:0]  SRC_POS_FIRST  = 8'h09;
  localparam logic [7:0]  SRC_POS_LAST   = 8'h0F;
  localparam logic [7:0]  SRC_PWM        = 8'h10;
  localparam logic [7:0]  SRC_PWM_INV    = 8'h11;

  // ------------------------------------------------------------
  // Brake PWM
  // ------------------------------------------------------------
  localparam logic [31:0] BRK_FREQ_MAX   = 32'h0000_07D0;
  localparam logic [31:0] BRK_FREQ_RST   = 32'h0000_07D0;
  localparam logic [6:0]  DUTY_MIN       = 7'h02;
  localparam logic [6:0]  DUTY_MAX       = 7'h64;
  localparam logic [6:0]  DUTY_RST       = 7'h64;
  localparam logic [6:0]  PCT_LAST       = 7'h63;
  localparam logic [6:0]  PCT_PER_HZ     = 7'h64;
  localparam int          ACC_W          = 29;
  localparam logic [ACC_W-1:0] ACC_MOD   = ACC_W'(CLK_HZ);

  // ------------------------------------------------------------
  // Object access carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } dopr_od_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] data;
  } dopr_od_rsp_t;

endpackage : dopr_pkg

// ---- dopr_incr_pulse.sv ----
// Increment pulse generator with power-of-two dividers
module dopr_incr_pulse
  import dopr_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic [31:0]        countValue,
  output logic      [NUM_DIV-1:0] pulseLevel
);

  localparam int CW = $clog2(PULSE_CYCLES + 1);

  if (PULSE_CYCLES < 1) begin : g_chk
    $error("PULSE_CYCLES must be at least one");
  end

  typedef struct packed {
    logic                          primed;
    logic [31:0]                   prev;
    logic [NUM_DIV-2:0]            incCnt;
    logic [NUM_DIV-1:0][CW-1:0]    stretch;
    logic [NUM_DIV-1:0]            level;
  } dopr_pulse_state_t;

  dopr_pulse_state_t state_reg;
  dopr_pulse_state_t state_next;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic                 step;
    logic [NUM_DIV-2:0]   cntNew;
    logic [NUM_DIV-2:0]   mask;
    mask       = '0;
    state_next = state_reg;
    step       = state_reg.primed && (countValue != state_reg.prev);
    cntNew     = state_reg.incCnt + (NUM_DIV-1)'(step);
    state_next.primed = 1'b1;
    state_next.prev   = countValue;
    state_next.incCnt = cntNew;
    for (int k = 0; k < NUM_DIV; k++) begin
      mask = (NUM_DIV-1)'((7'h01 << k) - 7'h01);
      if (step && ((cntNew & mask) == '0)) begin
        state_next.stretch[k] = CW'(PULSE_CYCLES);
      end else if (state_reg.stretch[k] != '0) begin
        state_next.stretch[k] = state_reg.stretch[k] - CW'(1);
      end
      state_next.level[k] = (state_next.stretch[k] != '0);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pulseLevel = state_reg.level;

endmodule : dopr_incr_pulse

// ---- dopr_load_model.sv ----
// Pull-up loads standing on the open-drain output pins
module dopr_load_model #(
  parameter int PINS = 6
) (
  input  wire logic [PINS-1:0] pinOut,
  input  wire logic [PINS-1:0] pinOe,
  output logic      [PINS-1:0] pinLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  // Enabled driver sinks the line, pull-up otherwise
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      pinLevel[i] = pinOe[i] ? pinOut[i] : 1'b1;
    end
  end
endmodule : dopr_load_model

// ---- dopr_output_router_props.sv ----
// Port checks of the output router
module dopr_output_router_props
  import dopr_pkg::*;
#(
  parameter int NUM_OUT = 4
) (
  input wire logic               core_clk,
  input wire logic               rstn,
  input wire dopr_od_req_t       odReq,
  input wire dopr_od_rsp_t       odRsp,
  input wire logic               errorState,
  input wire logic [NUM_OUT+1:0] pinOut,
  input wire logic [NUM_OUT+1:0] pinOe,
  input wire logic               ledGreen,
  input wire logic               ledRed
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] reqKey;
  assign reqKey = {odReq.index, odReq.sub};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_reset_released: assert property (
    $rose(rstn) |-> pinOe == '0 && !ledGreen && !ledRed) else $error("outputs active after reset");
  chk_open_drain: assert property (
    pinOut == '0) else $error("pin driven high");
  chk_green_no_error: assert property (
    ledGreen |-> !$past(errorState)) else $error("green lit in error");
  chk_red_on_error: assert property (
    ledRed |-> $past(errorState)) else $error("red lit without error");
  chk_request_ack: assert property (
    (odReq.wr || odReq.rd) |=> odRsp.ack) else $error("access not answered");
  chk_idle_quiet: assert property (
    !(odReq.wr || odReq.rd) |=> !odRsp.ack && !odRsp.err && odRsp.data == '0)
    else $error("answer without access");
  chk_freq_limit: assert property (
    odReq.wr && reqKey == KEY_BRK_FREQ && odReq.data > BRK_FREQ_MAX |=> odRsp.err)
    else $error("frequency above limit taken");
  chk_duty_range: assert property (
    odReq.wr && reqKey == KEY_BRK_DUTY && (odReq.data < 32'(DUTY_MIN) ||
    odReq.data > 32'(DUTY_MAX)) |=> odRsp.err) else $error("duty out of range taken");
  chk_applied_ro: assert property (
    odReq.wr && reqKey == KEY_APPLIED |=> odRsp.err) else $error("applied word written");
endmodule : dopr_output_router_props

bind dopr_output_router dopr_output_router_props #(.NUM_OUT(NUM_OUT)) chk_u (
  .core_clk(core_clk), .rstn(rstn), .odReq(odReq), .odRsp(odRsp), .errorState(errorState),
  .pinOut(pinOut), .pinOe(pinOe), .ledGreen(ledGreen), .ledRed(ledRed));

// ---- dopr_output_router_tb_top.sv ----
// Self-checking bench of the output router
module dopr_output_router_tb_top
  import dopr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int NO = 2;
  localparam int PW = NO + 2;
  localparam logic [23:0] RT_PWM = {OBJ_ROUTE, 8'h01};
  localparam logic [23:0] RT_O1  = {OBJ_ROUTE, 8'h02};
  localparam logic [23:0] RT_O2  = {OBJ_ROUTE, 8'h03};
  localparam logic [23:0] RW_KEYS [9] = '{KEY_OUT_CTRL, KEY_POLARITY, KEY_FORCE_EN,
    KEY_FORCE_VAL, KEY_ROUTE_EN, KEY_LED_CTRL, RT_PWM, RT_O1, RT_O2};
  logic          core_clk;
  logic          rstn;
  dopr_od_req_t  odReq;
  dopr_od_rsp_t  odRsp;
  logic [31:0]   encoderCount;
  logic [31:0]   positionValue;
  logic          errorState;
  logic [PW-1:0] pinLevel;
  logic [PW-1:0] pinOut;
  logic [PW-1:0] pinOe;
  logic          ledGreen;
  logic          ledRed;
  int            failCount;
  int            checksDone;

  dopr_output_router #(.NUM_OUT(NO), .PULSE_CYCLES(4), .BLINK_CYCLES(8)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .odReq(odReq), .odRsp(odRsp),
    .encoderCount(encoderCount), .positionValue(positionValue), .errorState(errorState),
    .pinIn(pinLevel), .pinOut(pinOut), .pinOe(pinOe), .ledGreen(ledGreen), .ledRed(ledRed));
  dopr_load_model #(.PINS(PW)) load_u (.pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic testDone;
    if (failCount == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : testDone

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic access(input logic wr, input logic [23:0] key, input logic [31:0] data,
                        output logic [31:0] rdData, output logic err);
    int n;
    @(negedge core_clk);
    odReq = '{wr, !wr, key[23:8], key[7:0], data};
    @(negedge core_clk);
    odReq = '0;
    n = 0;
    while (odRsp.ack !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    if (odRsp.ack !== 1'b1) begin
      failCount++;
      $display("BAD %0t no answer", $time);
      testDone();
    end
    rdData = odRsp.data;
    err = odRsp.err;
  endtask : access

  task automatic put(input logic [23:0] key, input logic [31:0] data, input logic expErr);
    logic [31:0] d;
    logic        e;
    access(1'b1, key, data, d, e);
    check({31'h0, e}, {31'h0, expErr}, "write answer");
  endtask : put

  task automatic get(input logic [23:0] key, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    access(1'b0, key, 32'h0, d, e);
    check({31'h0, e}, 32'h0, "read refused");
    check(d, exp, "read data");
  endtask : get

  task automatic pins(input logic [PW-1:0] act, input string what);
    logic [PW-1:0] lv;
    lv = ~act;
    repeat (3) @(negedge core_clk);
    check(32'(pinLevel), 32'(lv), what);
  endtask : pins

  task automatic clear;
    foreach (RW_KEYS[i]) put(RW_KEYS[i], 32'h0, 1'b0);
  endtask : clear

  task automatic leds(input logic [1:0] ctl, input logic err, input logic [1:0] exp);
    int g;
    int r;
    g = 0;
    r = 0;
    put(KEY_LED_CTRL, {30'h0, ctl}, 1'b0);
    errorState = err;
    repeat (40) begin
      @(negedge core_clk);
      g += int'(ledGreen === 1'b1);
      r += int'(ledRed === 1'b1);
    end
    check({30'h0, g > 0 && g < 40, r > 0 && r < 40}, {30'h0, exp}, "led blink");
  endtask : leds
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic testReset;
    foreach (RW_KEYS[i]) get(RW_KEYS[i], 32'h0);
    get(KEY_APPLIED, 32'h0);
    get(KEY_BRK_FREQ, BRK_FREQ_RST);
    get(KEY_BRK_DUTY, 32'(DUTY_RST));
    pins(4'h0, "reset pins");
  endtask : testReset

  task automatic testPlain;
    put(KEY_OUT_CTRL, 32'h0003_0001, 1'b0);
    pins(4'hD, "plain outputs");
    get(KEY_APPLIED, 32'h0003_0001);
    put(KEY_OUT_CTRL, 32'h0001_0002, 1'b0);
    pins(4'h4, "spare special bit");
  endtask : testPlain

  task automatic testMasks;
    put(KEY_OUT_CTRL, 32'h0001_0000, 1'b0);
    put(KEY_POLARITY, 32'h0003_0000, 1'b0);
    pins(4'h8, "inverted");
    get(KEY_APPLIED, 32'h0002_0000);
    put(KEY_FORCE_EN, 32'h0002_0001, 1'b0);
    put(KEY_FORCE_VAL, 32'h0000_0001, 1'b0);
    pins(4'h1, "forced");
    clear();
  endtask : testMasks

  task automatic testRouting;
    put(RT_O1, 32'h0005, 1'b0);
    put(RT_PWM, 32'h0005, 1'b0);
    put(KEY_OUT_CTRL, 32'h0000_0020, 1'b0);
    put(KEY_ROUTE_EN, 32'h2, 1'b0);
    pins(4'h0, "routing off");
    put(KEY_ROUTE_EN, 32'h1, 1'b0);
    pins(4'h6, "routed one");
    put(KEY_OUT_CTRL, 32'h0, 1'b0);
    pins(4'h0, "gate closed");
    put(RT_O1, 32'h0085, 1'b0);
    put(RT_O2, 32'h0185, 1'b0);
    pins(4'h4, "inverted gate");
    put(RT_O2, 32'h1080, 1'b0);
    pins(4'hC, "brake pwm");
    put(RT_O2, 32'h1180, 1'b0);
    pins(4'h4, "inverse pwm");
    clear();
  endtask : testRouting

  task automatic testRefuse;
    put(KEY_BRK_FREQ, 32'h0000_07D1, 1'b1);
    get(KEY_BRK_FREQ, 32'h0000_07D0);
    put(KEY_BRK_DUTY, 32'h1, 1'b1);
    put(KEY_BRK_DUTY, 32'h65, 1'b1);
    put(KEY_BRK_DUTY, 32'h2, 1'b0);
    get(KEY_BRK_DUTY, 32'h2);
    put(KEY_BRK_DUTY, 32'h64, 1'b0);
    put(KEY_APPLIED, 32'h1, 1'b1);
    put(24'h325001, 32'h1, 1'b1);
  endtask : testRefuse

  task automatic testPulses;
    int   pulses;
    logic prev;
    put(KEY_ROUTE_EN, 32'h1, 1'b0);
    put(KEY_OUT_CTRL, 32'h1, 1'b0);
    for (int c = 2; c < 16; c++) begin
      put(RT_O1, {16'h0, 8'(c), 8'h00}, 1'b0);
      pulses = 0;
      prev = 1'b1;
      repeat (64) begin
        if (c < 9) encoderCount = encoderCount + 32'h1;
        else positionValue = positionValue - 32'h1;
        repeat (10) begin
          @(negedge core_clk);
          if (prev === 1'b1 && pinLevel[2] === 1'b0) pulses++;
          prev = pinLevel[2];
        end
      end
      check(32'(pulses), 32'(32'h40 >> ((c - 2) % 7)), "pulse count");
    end
    clear();
  endtask : testPulses

  initial begin
    rstn = 1'b0;
    odReq = '0;
    encoderCount = 32'h0;
    positionValue = 32'h0;
    errorState = 1'b0;
    failCount = 0;
    checksDone = 0;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    testReset();
    testPlain();
    testMasks();
    testRouting();
    testRefuse();
    testPulses();
    leds(2'b11, 1'b0, 2'b10);
    leds(2'b11, 1'b1, 2'b01);
    leds(2'b01, 1'b1, 2'b00);
    leds(2'b10, 1'b0, 2'b00);
    testDone();
  end
endmodule : dopr_output_router_tb_top
